// ==== tpw_pin_load.sv ====
// Load on one unit pin, pulled down, measuring high time and period.
// Assumes driver and enable change on the unit clock.
`timescale 1ns/1ps
`default_nettype none
module tpw_pin_load (
	// Clock and pin driver
	input wire logic clk,
	input wire logic drive,
	input wire logic oe,
	// Wire level and last full period, in clocks
	output logic level,
	output logic [15:0] hi_len,
	output logic [15:0] per_len
);
	logic prev = 1'b0;
	logic [15:0] hi_cnt = '0;
	logic [15:0] per_cnt = '0;
	// Released pin falls to the pull-down, never keeps the old value
	assign level = oe ? drive : 1'b0;
	always @(posedge clk) begin
		prev <= level;
		if (level && !prev) begin
			hi_len <= hi_cnt;
			per_len <= per_cnt;
			hi_cnt <= 16'h0001;
			per_cnt <= 16'h0001;
		end else begin
			hi_cnt <= hi_cnt + 16'(level);
			per_cnt <= per_cnt + 16'h0001;
		end
	end
endmodule // tpw_pin_load
`default_nettype wire

// ==== tpw_pkg.sv ====
// Package for the timer based pulse width unit: register map, fields, reset values.
// Assumes a byte-wide register port with one-cycle read latency.
package tpw_pkg;
	localparam int NUM_CH = 2;
	// Register indices (byte addresses on the plain port)
	localparam logic [3:0] ADDR_PERIOD = 4'h0;
	localparam logic [3:0] ADDR_TBCTRL = 4'h1;
	localparam logic [3:0] ADDR_COUNT = 4'h2;
	localparam logic [3:0] ADDR_PINDIR = 4'h3;
	localparam logic [3:0] ADDR_CH_BASE = 4'h4;
	localparam logic [3:0] ADDR_CH_STRIDE = 4'h4;
	localparam logic [1:0] OFS_CTRL = 2'h0;
	localparam logic [1:0] OFS_DUTY_UP = 2'h1;
	localparam logic [1:0] OFS_DUTY_LO = 2'h2;
	// Channel control fields
	localparam int BIT_EN = 7;
	localparam int BIT_OE = 6;
	localparam int BIT_OUT = 5;
	localparam int BIT_POL = 4;
	// Timebase control fields
	localparam int BIT_TB_ON = 2;
	localparam int PS_LSB = 0;
	// Prescale select codes
	localparam logic [1:0] PS_1 = 2'h0;
	localparam logic [1:0] PS_4 = 2'h1;
	localparam logic [1:0] PS_16 = 2'h2;
	localparam logic [1:0] PS_64 = 2'h3;
	// Reset values
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [NUM_CH-1:0] RST_PINDIR = {NUM_CH{1'b1}};
endpackage

// ==== tpw_unit.sv ====
// Timer based pulse width unit: shared 8-bit timebase, two channels, pin muxing.
// Assumes a synchronous register port and a sleep request from the system.
//
// Functional notes
// (RULE_01) Outputs go active when timebase count clears
// (RULE_02) Output inactive when 10-bit base equals duty
// (RULE_03) Duty at or above period: never inactive
// (RULE_04) Duty registers shadowed, reload at period match
// (RULE_05) Period match: clear count, set output, reload
// (RULE_06) Zero duty keeps output inactive at restart
// (RULE_07) Polarity bit inverts the channel output
// (RULE_08) Period is (period+1) times 4 times prescale
// (RULE_09) Shared period, independent duty per channel
// (RULE_10) Postscaler plays no part in timing
// (RULE_11) Two low bits from clock or prescaler
// (RULE_12) Duty writes allowed anytime, applied at reload
// (RULE_13) Software writes both duty halves before match
// (RULE_14) Pin driven only when enabled and output direction
// (RULE_15) Clearing output enable returns pin to latch
// (RULE_16) Duty above period leaves pin level unchanged
// (RULE_17) Resolution follows log2 of four times period
// (RULE_18) Sleep stops count and holds all state; here register writes still land and pins with output enable clear follow the latch in sleep
// (RULE_19) After wake count resumes from held value
// (RULE_20) Channel enable is control bit 7
// (RULE_21) Polarity select is control bit 4
// (RULE_22) Reset sets inputs and register reset values
// (RULE_23) Disabled channel holds output inactive
// (RULE_24) Output level readable in control bit 5
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module tpw_unit
	import tpw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Power state
	input wire logic sleep,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Port data latch values to share the pins
	input wire logic [NUM_CH-1:0] port_latch,
	// Pins
	output logic [NUM_CH-1:0] pin_out,
	output logic [NUM_CH-1:0] pin_oe
);

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] period_register;
	logic [7:0] timebase_control;
	logic [7:0] timebase_count;
	logic [NUM_CH-1:0] pin_direction_bits;
	logic [7:0] duty_cycle_upper [NUM_CH];
	logic [1:0] duty_cycle_lower [NUM_CH];
	logic [NUM_CH-1:0] module_enable_bit;
	logic [NUM_CH-1:0] pin_output_enable;
	logic [NUM_CH-1:0] output_polarity_select;
	logic [9:0] duty_shadow [NUM_CH];
	logic [NUM_CH-1:0] pwm_level;
	logic [5:0] prescale_cnt;
	logic [1:0] sub_cnt;
	logic [7:0] next_rdata;
	logic run;
	logic step;
	logic sub_wrap;
	logic period_match;
	logic restart;
	logic [9:0] time_base;
	logic [9:0] next_time_base;
	logic [NUM_CH-1:0] shown_level;

	logic ch_hit;
	logic [1:0] ch_ofs;
	logic [0:0] ch_idx;
	assign ch_hit = (reg_addr >= ADDR_CH_BASE) && (reg_addr < ADDR_CH_BASE + 4'(NUM_CH) * ADDR_CH_STRIDE);
	assign ch_idx = 1'((reg_addr - ADDR_CH_BASE) >> 2);
	assign ch_ofs = reg_addr[1:0];

	// Clock enable low freezes everything, sleep only the timebase and modulator levels; no reinit on wake
	assign run = ce && !sleep && timebase_control[BIT_TB_ON]; // RULE_18 RULE_19

	////////////////////////////////////////////////////////////////////
	// Prescaler: one quarter-step every 1, 4, 16 or 64 clocks
	always_comb begin
		case (timebase_control[PS_LSB +: 2])
			PS_1: step = 1'b1; // RULE_11
			PS_4: step = (prescale_cnt[1:0] == 2'h3);
			PS_16: step = (prescale_cnt[3:0] == 4'hF);
			PS_64: step = (prescale_cnt == 6'h3F);
			default: step = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prescale_cnt <= 6'h00;
		end else if (run) begin
			prescale_cnt <= step ? 6'h00 : prescale_cnt + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timebase: two low bits below the 8-bit count; no postscaler used
	assign sub_wrap = step && (sub_cnt == 2'h3);
	assign period_match = (timebase_count == period_register);
	assign restart = run && sub_wrap && period_match; // RULE_05 RULE_08 RULE_10
	assign time_base = {timebase_count, sub_cnt}; // RULE_11 RULE_17
	// Clear on the step that enters the duty value, so width is duty times prescale
	assign next_time_base = time_base + 10'h001;

	always_ff @(posedge clk) begin
		if (rst) begin
			sub_cnt <= 2'h0;
		end else if (run && step) begin
			sub_cnt <= sub_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			timebase_count <= RST_ZERO;
		end else if (ce && reg_wr && reg_addr == ADDR_COUNT) begin
			timebase_count <= reg_wdata;
		end else if (restart) begin
			timebase_count <= RST_ZERO; // RULE_05 RULE_08
		end else if (run && sub_wrap) begin
			timebase_count <= timebase_count + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared registers
	always_ff @(posedge clk) begin
		if (rst) begin
			period_register <= RST_PERIOD; // RULE_22
			timebase_control <= RST_ZERO;
			pin_direction_bits <= RST_PINDIR; // RULE_22
		end else if (ce && reg_wr) begin
			if (reg_addr == ADDR_PERIOD)
				period_register <= reg_wdata;
			if (reg_addr == ADDR_TBCTRL)
				timebase_control <= reg_wdata & 8'h07;
			if (reg_addr == ADDR_PINDIR)
				pin_direction_bits <= reg_wdata[NUM_CH-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Channels
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic wr_here;
		assign wr_here = ce && reg_wr && ch_hit && (ch_idx == 1'(i));

		always_ff @(posedge clk) begin
			if (rst) begin
				module_enable_bit[i] <= 1'b0;
				pin_output_enable[i] <= 1'b0;
				output_polarity_select[i] <= 1'b0;
				duty_cycle_upper[i] <= RST_ZERO;
				duty_cycle_lower[i] <= 2'h0;
			end else if (wr_here) begin
				// Duty writes only land in the staging registers
				case (ch_ofs)
					OFS_CTRL: begin
						module_enable_bit[i] <= reg_wdata[BIT_EN]; // RULE_20
						pin_output_enable[i] <= reg_wdata[BIT_OE];
						output_polarity_select[i] <= reg_wdata[BIT_POL]; // RULE_21
					end
					OFS_DUTY_UP: duty_cycle_upper[i] <= reg_wdata; // RULE_12
					OFS_DUTY_LO: duty_cycle_lower[i] <= reg_wdata[7:6]; // RULE_12
					default: ;
				endcase
			end
		end

		// Both halves latched together; a half-written pair is software's risk
		always_ff @(posedge clk) begin
			if (rst) begin
				duty_shadow[i] <= 10'h000;
			end else if (restart) begin
				duty_shadow[i] <= {duty_cycle_upper[i], duty_cycle_lower[i]}; // RULE_04 RULE_05 RULE_13
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				pwm_level[i] <= 1'b0;
			end else if (ce && !sleep && !module_enable_bit[i]) begin
				pwm_level[i] <= 1'b0; // RULE_23
			end else if (restart) begin
				// Zero duty never goes active; shared restart for all channels
				pwm_level[i] <= ({duty_cycle_upper[i], duty_cycle_lower[i]} != 10'h000); // RULE_01 RULE_06 RULE_09
			end else if (run && step && (next_time_base == duty_shadow[i])
					&& (duty_shadow[i][9:2] < period_register)) begin
				pwm_level[i] <= 1'b0; // RULE_02 RULE_03 RULE_16
			end
		end

		assign shown_level[i] = pwm_level[i] ^ output_polarity_select[i]; // RULE_07

		// Pin mux: modulator only while enabled and direction is output
		always_ff @(posedge clk) begin
			if (rst) begin
				pin_oe[i] <= 1'b0; // RULE_22
				pin_out[i] <= 1'b0;
			end else if (ce) begin
				pin_oe[i] <= !pin_direction_bits[i]; // RULE_14
				pin_out[i] <= pin_output_enable[i] ? shown_level[i] : port_latch[i]; // RULE_14 RULE_15
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path, one cycle latency; unmapped reads return zero
	always_comb begin
		next_rdata = 8'h00;
		if (ch_hit) begin
			case (ch_ofs)
				OFS_CTRL: begin
					next_rdata[BIT_EN] = module_enable_bit[ch_idx];
					next_rdata[BIT_OE] = pin_output_enable[ch_idx];
					next_rdata[BIT_OUT] = shown_level[ch_idx]; // RULE_24
					next_rdata[BIT_POL] = output_polarity_select[ch_idx];
				end
				OFS_DUTY_UP: next_rdata = duty_cycle_upper[ch_idx];
				OFS_DUTY_LO: next_rdata = {duty_cycle_lower[ch_idx], 6'h00};
				default: next_rdata = 8'h00;
			endcase
		end else begin
			case (reg_addr)
				ADDR_PERIOD: next_rdata = period_register;
				ADDR_TBCTRL: next_rdata = timebase_control;
				ADDR_COUNT: next_rdata = timebase_count;
				ADDR_PINDIR: next_rdata = {{(8-NUM_CH){1'b0}}, pin_direction_bits};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

endmodule // tpw_unit

`default_nettype wire

// ==== tpw_unit_assertions.sv ====
// Port checker for the pulse width unit.
// Assumes a bind into tpw_unit; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tpw_unit_chk
	import tpw_pkg::*;
(
	// Control and register strobes
	input wire logic clk, rst, ce, sleep, reg_wr, reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	// Pins
	input wire logic [NUM_CH-1:0] port_latch, pin_out, pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	reset_clear_a: assert property (
		$fell(rst) |-> pin_oe == '0 && pin_out == '0 && reg_rdata == 8'h00) else $error("outputs not cleared by reset");
	read_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero without a read");
	unmapped_read_a: assert property (ce && reg_rd && reg_addr > 4'hA |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_reserved_a: assert property (
		ce && reg_rd && reg_addr >= ADDR_CH_BASE && reg_addr[1:0] == OFS_CTRL |=> reg_rdata[3:0] == 4'h0)
		else $error("control reserved bits not zero");
	low_reserved_a: assert property (
		ce && reg_rd && reg_addr >= ADDR_CH_BASE && reg_addr[1:0] == OFS_DUTY_LO |=> reg_rdata[5:0] == 6'h00)
		else $error("duty low reserved bits not zero");
	freeze_hold_a: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(reg_rdata))
		else $error("outputs moved with clock enable low");
	oe_quiet_a: assert property ((ce && !reg_wr)[*2] |=> $stable(pin_oe))
		else $error("pin enable changed without a write");
	sleep_pin_a: assert property (
		(sleep && ce && !reg_wr && $stable(port_latch))[*4] |-> $stable(pin_out)) else $error("pin moved in sleep");
	cover property ($rose(pin_out[0]));
	cover property (sleep [*4]);
	cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule // tpw_unit_chk

bind tpw_unit tpw_unit_chk u_chk (.clk, .rst, .ce, .sleep, .reg_wr, .reg_rd, .reg_addr, .reg_rdata,
	.port_latch, .pin_out, .pin_oe);
`default_nettype wire

// ==== tpw_unit_tb_top.sv ====
// Testbench for the pulse width unit: register tasks and pin measurement.
// Assumes tpw_pkg, the checker bind and the pin load model.
`timescale 1ns/1ps
`default_nettype none
module tpw_unit_tb_top
	import tpw_pkg::*;
();
	logic clk = 0, rst = 1, ce = 1, sleep = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata;
	logic [1:0] port_latch = '0, pin_out, pin_oe, level;
	logic [15:0] hi_len [2], per_len [2];
	int n_fail = 0, num_checks = 0;
	always #25 clk = ~clk;
	tpw_unit dut (.clk, .rst, .ce, .sleep, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.port_latch, .pin_out, .pin_oe);
	for (genvar i = 0; i < 2; i++) begin : g_load
		tpw_pin_load ld (.clk, .drive(pin_out[i]), .oe(pin_oe[i]), .level(level[i]), .hi_len(hi_len[i]),
			.per_len(per_len[i]));
	end
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(16'(reg_rdata), 16'(e), "read data");
	endtask
	// Both duty halves go in before the next restart
	task automatic cfg(input logic ch, input logic [7:0] c, input logic [7:0] up, input logic [7:0] lo);
		wr(ADDR_CH_BASE + (ch ? ADDR_CH_STRIDE : 4'h0) + 4'(OFS_CTRL), c);
		wr(ADDR_CH_BASE + (ch ? ADDR_CH_STRIDE : 4'h0) + 4'(OFS_DUTY_UP), up);
		wr(ADDR_CH_BASE + (ch ? ADDR_CH_STRIDE : 4'h0) + 4'(OFS_DUTY_LO), lo);
	endtask
	task automatic hold(input logic [1:0] e);
		repeat (16) begin
			@(posedge clk);
			#1 chk(16'(level), 16'(e), "pin level");
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run;
	end
	initial begin
		int ps;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_PERIOD, RST_PERIOD);
		rd(ADDR_PINDIR, 8'(RST_PINDIR));
		rd(ADDR_CH_BASE, RST_ZERO);
		rd(4'hF, 8'h00);
		wr(ADDR_CH_BASE + 4'(OFS_DUTY_LO), 8'hFF);
		rd(ADDR_CH_BASE + 4'(OFS_DUTY_LO), 8'hC0);
		$display("reset and map test done");
		wr(ADDR_PERIOD, 8'h01);
		wr(ADDR_PINDIR, 8'h00);
		cfg(1'b0, 8'hC0, 8'h00, 8'h80);
		cfg(1'b1, 8'hD0, 8'h00, 8'hC0);
		for (int p = 0; p < 4; p++) begin
			ps = 1 << (2 * p);
			wr(ADDR_TBCTRL, 8'h04 | 8'(p));
			repeat (24 * ps + 4) @(posedge clk);
			#1 chk(per_len[0], 16'(8 * ps), "period 0");
			chk(hi_len[0], 16'(2 * ps), "width 0");
			chk(per_len[1], 16'(8 * ps), "period 1");
			chk(hi_len[1], 16'(5 * ps), "width 1");
		end
		$display("period and prescale test done");
		wr(ADDR_TBCTRL, 8'h04);
		cfg(1'b0, 8'hC0, 8'h01, 8'h00);
		cfg(1'b1, 8'hD0, 8'h00, 8'h00);
		repeat (20) @(posedge clk);
		hold(2'b11);
		wr(ADDR_CH_BASE, 8'h40);
		wr(ADDR_CH_BASE + ADDR_CH_STRIDE, 8'h50);
		repeat (4) @(posedge clk);
		hold(2'b10);
		port_latch <= 2'b01;
		wr(ADDR_CH_BASE, 8'h80);
		repeat (4) @(posedge clk);
		hold(2'b11);
		port_latch <= 2'b00;
		repeat (3) @(posedge clk);
		hold(2'b10);
		wr(ADDR_PINDIR, 8'h03);
		repeat (3) @(posedge clk);
		#1 chk(16'(pin_oe), 16'h0000, "pin enable");
		$display("pin and limit test done");
		wr(ADDR_TBCTRL, 8'h00);
		wr(ADDR_COUNT, 8'h01);
		sleep <= 1'b1;
		wr(ADDR_TBCTRL, 8'h04);
		repeat (20) @(posedge clk);
		rd(ADDR_COUNT, 8'h01);
		sleep <= 1'b0;
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		$display("sleep and freeze test done");
		complete_run;
	end
endmodule // tpw_unit_tb_top
`default_nettype wire
